// ---- verilog/lrcr_regs.sv ----
// Purpose: lane 1 pair configuration and status registers
// Assumes: byte register port driven by the management front end on sys_clk
// Notes:   analog observation inputs are asynchronous and synchronised here
`timescale 1ns/1ns

module lrcr_regs #(
  parameter int DETECT_PERIOD_CYC = lrcr_pkg::DETECT_PERIOD_CYC,
  parameter int DETECT_ATTEMPTS   = lrcr_pkg::DETECT_ATTEMPTS,
  parameter int TEST_WINDOW_CYC   = lrcr_pkg::TEST_WINDOW_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_ack,
  input  wire logic       idle_sensed,
  input  wire logic [1:0] rate_sensed,
  input  wire logic       far_rx_sense,
  output logic            output_mute,
  output logic            input_term_50ohm,
  output logic            rx_test_pulse,
  output logic      [7:0] input_boost_level,
  output logic            short_protect_en,
  output logic            rate_class_gen12,
  output logic      [2:0] output_swing_level,
  output logic      [2:0] output_deemphasis_level
);

  logic [7:0] idle_pres_q;
  logic [7:0] eq_q;
  logic [7:0] swing_q;
  logic [4:0] deemph_q;
  logic [7:0] rdata_q;
  logic       ack_q;
  logic       mute_q;

  logic       idle_s1_q, idle_s2_q, idle_s3_q, idle_q;
  logic [1:0] rate_s1_q, rate_s2_q, rate_s3_q, rate_q;

  logic       far_receiver_found_flag;
  logic [1:0] detected_rate_class;
  logic [1:0] far_receiver_presence_mode;
  logic       idle_auto;
  logic       idle_manual;
  logic       term_50;

  assign idle_auto                  = idle_pres_q[lrcr_pkg::IDLE_AUTO_BIT];
  assign idle_manual                = idle_pres_q[lrcr_pkg::IDLE_SEL_BIT];
  assign far_receiver_presence_mode = idle_pres_q[lrcr_pkg::PRES_MODE_LSB +: 2];
  assign detected_rate_class        = rate_q;

  // register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      idle_pres_q <= lrcr_pkg::IDLE_PRES_RST;
      eq_q        <= lrcr_pkg::EQ_RST;
      swing_q     <= lrcr_pkg::SWING_RST;
      deemph_q    <= lrcr_pkg::DEEMPH_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        lrcr_pkg::IDLE_PRES_OFFS: idle_pres_q <= reg_wdata;
        lrcr_pkg::EQ_OFFS:        eq_q        <= reg_wdata;
        lrcr_pkg::SWING_OFFS:     swing_q     <= reg_wdata;
        // status bits 7:5 are not writable
        lrcr_pkg::DEEMPH_OFFS:    deemph_q    <= reg_wdata[4:0];
        default:                  ;
      endcase
    end
  end

  // register reads, one cycle latency
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= lrcr_pkg::UNMAPPED_DATA;
    end else if (reg_rd) begin
      unique case (reg_addr)
        lrcr_pkg::IDLE_PRES_OFFS: rdata_q <= idle_pres_q;
        lrcr_pkg::EQ_OFFS:        rdata_q <= eq_q;
        lrcr_pkg::SWING_OFFS:     rdata_q <= swing_q;
        lrcr_pkg::DEEMPH_OFFS:    rdata_q <= {far_receiver_found_flag, detected_rate_class, deemph_q};
        default:                  rdata_q <= lrcr_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) ack_q <= 1'b0;
    else     ack_q <= reg_rd | reg_wr;
  end

  assign reg_rdata = rdata_q;
  assign reg_ack   = ack_q;

  // idle detector sync, change taken when last two agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      idle_s1_q <= 1'b0;
      idle_s2_q <= 1'b0;
      idle_s3_q <= 1'b0;
      idle_q    <= 1'b0;
    end else begin
      idle_s1_q <= idle_sensed;
      idle_s2_q <= idle_s1_q;
      idle_s3_q <= idle_s2_q;
      if (idle_s2_q == idle_s3_q) idle_q <= idle_s3_q;
    end
  end

  // rate detector sync, change taken when last two agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rate_s1_q <= 2'b00;
      rate_s2_q <= 2'b00;
      rate_s3_q <= 2'b00;
      rate_q    <= 2'b00;
    end else begin
      rate_s1_q <= rate_sensed;
      rate_s2_q <= rate_s1_q;
      rate_s3_q <= rate_s2_q;
      if (rate_s2_q == rate_s3_q) rate_q <= rate_s3_q;
    end
  end

  // output muting: detector in auto, else manual bit
  always_ff @(posedge sys_clk) begin
    if (rst) mute_q <= 1'b0;
    else     mute_q <= idle_auto ? idle_q : idle_manual;
  end

  assign output_mute = mute_q;

  // register field drives presence mode, no pin path
  lrcr_rx_detect #(
    .PERIOD_CYC (DETECT_PERIOD_CYC),
    .ATTEMPTS   (DETECT_ATTEMPTS),
    .WINDOW_CYC (TEST_WINDOW_CYC)
  ) u_rx_detect (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .pres_mode     (far_receiver_presence_mode),
    .far_rx_sense  (far_rx_sense),
    .rx_test_pulse (rx_test_pulse),
    .found_q       (far_receiver_found_flag),
    .term_50_q     (term_50)
  );

  assign input_term_50ohm        = term_50;
  assign input_boost_level       = eq_q;
  assign short_protect_en        = swing_q[lrcr_pkg::SC_PROT_BIT];
  assign rate_class_gen12        = swing_q[lrcr_pkg::RATE_SEL_BIT];
  assign output_swing_level      = swing_q[lrcr_pkg::SWING_LSB +: 3];
  assign output_deemphasis_level = deemph_q[lrcr_pkg::DEEMPH_LSB +: 3];

  // checks
  sequence seq_write_eq;
    reg_wr && reg_addr == lrcr_pkg::EQ_OFFS;
  endsequence
  sequence seq_read_status;
    reg_rd && !reg_wr && reg_addr == lrcr_pkg::DEEMPH_OFFS;
  endsequence
  sequence seq_write_manual;
    reg_wr && reg_addr == lrcr_pkg::IDLE_PRES_OFFS && !reg_wdata[lrcr_pkg::IDLE_AUTO_BIT];
  endsequence

  AST_MUTE_MANUAL:
  assert property (@(posedge sys_clk) disable iff (rst)
    !idle_auto |=> output_mute == $past(idle_manual))
    else $error("manual idle bit not applied to mute");

  AST_MUTE_AUTO:
  assert property (@(posedge sys_clk) disable iff (rst)
    idle_auto |=> output_mute == $past(idle_q))
    else $error("auto idle not following detector");

  AST_MUTE_OVERRIDE:
  assert property (@(posedge sys_clk) disable iff (rst)
    !idle_auto && idle_manual ##1 !idle_auto && idle_manual |=> output_mute)
    else $error("manual mute not held");

  AST_RESET_DEFAULTS:
  assert property (@(posedge sys_clk)
    rst |=> eq_q == 8'h2f && swing_q == 8'had && deemph_q == 5'h02 && idle_pres_q == 8'h00)
    else $error("defaults not loaded on reset");

  AST_EQ_WRITE:
  assert property (@(posedge sys_clk) disable iff (rst)
    seq_write_eq |=> input_boost_level == $past(reg_wdata))
    else $error("boost level write lost");

  AST_ACK_ONE_CYCLE:
  assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd || reg_wr) |=> reg_ack ##1 (reg_ack == $past(reg_rd || reg_wr)))
    else $error("ack timing wrong");

  AST_STATUS_READ:
  assert property (@(posedge sys_clk) disable iff (rst)
    seq_read_status |=> reg_rdata[7] == $past(far_receiver_found_flag) && reg_rdata[6:5] == $past(rate_q))
    else $error("status bits misreported");

  AST_RATE_CLASS:
  assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == lrcr_pkg::SWING_OFFS |=> rate_class_gen12 == $past(reg_wdata[6])
      && short_protect_en == $past(reg_wdata[7]))
    else $error("rate class or protection not taken from write");

  AST_SWING_DEEMPH:
  assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == lrcr_pkg::DEEMPH_OFFS |=> output_deemphasis_level == $past(reg_wdata[2:0])
      && output_swing_level == $past(output_swing_level))
    else $error("de-emphasis write disturbed or lost");

  AST_RATE_SYNC:
  assert property (@(posedge sys_clk) disable iff (rst)
    rate_s2_q == rate_s3_q |=> rate_q == $past(rate_s3_q))
    else $error("rate status not updated after agreement");

  AST_PRES_MODE:
  assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == lrcr_pkg::IDLE_PRES_OFFS && reg_wdata[3:2] == 2'b11 ##1 !reg_wr |=> input_term_50ohm)
    else $error("presence field not governing termination");

  AST_UNMAPPED_READ:
  assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && (reg_addr < 8'h15 || reg_addr > 8'h18) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  AST_MANUAL_WRITE_MUTE:
  assert property (@(posedge sys_clk) disable iff (rst)
    seq_write_manual |-> ##2 output_mute == $past(reg_wdata[lrcr_pkg::IDLE_SEL_BIT], 2))
    else $error("manual idle write not applied to mute");

  AST_PRES_HIGHZ_WRITE:
  assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == lrcr_pkg::IDLE_PRES_OFFS && reg_wdata[3:2] == 2'b00 ##1 !reg_wr |=> !input_term_50ohm)
    else $error("presence field 00 not governing termination");

  AST_SWING_WRITE:
  assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == lrcr_pkg::SWING_OFFS |=> output_swing_level == $past(reg_wdata[2:0]))
    else $error("swing write lost");

  AST_SWING_HOLD:
  assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr && reg_addr == lrcr_pkg::SWING_OFFS) |=> $stable(output_swing_level))
    else $error("swing level changed without a write");

  AST_PROT_HOLD:
  assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr && reg_addr == lrcr_pkg::SWING_OFFS) |=> $stable(short_protect_en))
    else $error("protection enable changed without a write");

  AST_RATE_SEL_HOLD:
  assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr && reg_addr == lrcr_pkg::SWING_OFFS) |=> $stable(rate_class_gen12))
    else $error("rate class changed without a write");

  AST_BOOST_HOLD:
  assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr && reg_addr == lrcr_pkg::EQ_OFFS) |=> $stable(input_boost_level))
    else $error("boost level changed without a write");

  AST_DEEMPH_HOLD:
  assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr && reg_addr == lrcr_pkg::DEEMPH_OFFS) |=> $stable(output_deemphasis_level))
    else $error("de-emphasis changed without a write");

  AST_UNMAPPED_WRITE:
  assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && (reg_addr < lrcr_pkg::IDLE_PRES_OFFS || reg_addr > lrcr_pkg::DEEMPH_OFFS)
      |=> $stable(idle_pres_q) && $stable(eq_q) && $stable(swing_q) && $stable(deemph_q))
    else $error("unmapped write disturbed a register");

  AST_RDATA_HOLD:
  assert property (@(posedge sys_clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  AST_ACK_IDLE:
  assert property (@(posedge sys_clk) disable iff (rst)
    !reg_rd && !reg_wr |=> !reg_ack)
    else $error("ack without request");

  AST_OUTPUTS_RESET:
  assert property (@(posedge sys_clk)
    rst |=> !output_mute && !input_term_50ohm && !reg_ack && reg_rdata == lrcr_pkg::UNMAPPED_DATA)
    else $error("outputs not at reset values");

endmodule : lrcr_regs

// ---- verilog/lrcr_pkg.sv ----
// Purpose: shared constants for the lane 1 pair configuration registers
// Assumes: 250 MHz sys_clk, byte-wide register port
// Notes:   offsets are byte addresses on the management register port
package lrcr_pkg;

  // register offsets
  localparam logic [7:0] IDLE_PRES_OFFS = 8'h15;
  localparam logic [7:0] EQ_OFFS        = 8'h16;
  localparam logic [7:0] SWING_OFFS     = 8'h17;
  localparam logic [7:0] DEEMPH_OFFS    = 8'h18;

  // values after reset
  localparam logic [7:0] IDLE_PRES_RST = 8'h00;
  localparam logic [7:0] EQ_RST        = 8'h2f;
  localparam logic [7:0] SWING_RST     = 8'had;
  localparam logic [4:0] DEEMPH_RST    = 5'h02;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // field positions
  localparam int IDLE_AUTO_BIT  = 5;
  localparam int IDLE_SEL_BIT   = 4;
  localparam int PRES_MODE_LSB  = 2;
  localparam int SC_PROT_BIT    = 7;
  localparam int RATE_SEL_BIT   = 6;
  localparam int SWING_LSB      = 0;
  localparam int FOUND_BIT      = 7;
  localparam int RATE_DET_LSB   = 5;
  localparam int DEEMPH_LSB     = 0;

  // presence-detect modes
  typedef enum logic [1:0] {
    PRES_HIGHZ       = 2'b00,
    PRES_DET_LIMITED = 2'b01,
    PRES_DET_FOREVER = 2'b10,
    PRES_FIXED_50    = 2'b11
  } lrcr_pres_mode_type;

  // detect engine states
  typedef enum logic [1:0] {
    DET_OFF  = 2'b00,
    DET_WAIT = 2'b01,
    DET_TEST = 2'b10,
    DET_DONE = 2'b11
  } lrcr_det_state_type;

  // detect timing
  localparam int SYS_CLK_KHZ       = 250000;
  localparam int DETECT_PERIOD_MS  = 12;
  localparam int DETECT_SPAN_MS    = 600;
  localparam int DETECT_PERIOD_CYC = DETECT_PERIOD_MS * SYS_CLK_KHZ;
  localparam int DETECT_ATTEMPTS   = DETECT_SPAN_MS / DETECT_PERIOD_MS;
  localparam int TEST_WINDOW_CYC   = 4;

endpackage : lrcr_pkg

// ---- verilog/lrcr_rx_detect.sv ----
// Purpose: far-end receiver presence engine and input termination control
// Assumes: far_rx_sense is an asynchronous level from the analog detector
// Notes:   first test fires one full period after an auto mode is entered
`timescale 1ns/1ns
module lrcr_rx_detect #(
  parameter int PERIOD_CYC = lrcr_pkg::DETECT_PERIOD_CYC,
  parameter int ATTEMPTS   = lrcr_pkg::DETECT_ATTEMPTS,
  parameter int WINDOW_CYC = lrcr_pkg::TEST_WINDOW_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [1:0] pres_mode,
  input  wire logic       far_rx_sense,
  output logic            rx_test_pulse,
  output logic            found_q,
  output logic            term_50_q
);
  localparam int CNT_W = $clog2(PERIOD_CYC + 1);
  localparam int ATT_W = $clog2(ATTEMPTS + 1);
  localparam int WIN_W = $clog2(WINDOW_CYC + 1);

  lrcr_pkg::lrcr_det_state_type state_q;
  logic [CNT_W-1:0] period_cnt_q;
  logic [ATT_W-1:0] attempt_q;
  logic [WIN_W-1:0] win_cnt_q;
  logic [1:0]       mode_prev_q;
  logic             sense_s1_q, sense_s2_q, sense_s3_q, sense_q;
  logic             auto_mode;

  assign auto_mode     = (pres_mode == lrcr_pkg::PRES_DET_LIMITED) || (pres_mode == lrcr_pkg::PRES_DET_FOREVER);
  assign rx_test_pulse = (state_q == lrcr_pkg::DET_TEST);

  // three-stage sync, change taken when last two agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sense_s1_q <= 1'b0;
      sense_s2_q <= 1'b0;
      sense_s3_q <= 1'b0;
      sense_q    <= 1'b0;
    end else begin
      sense_s1_q <= far_rx_sense;
      sense_s2_q <= sense_s1_q;
      sense_s3_q <= sense_s2_q;
      if (sense_s2_q == sense_s3_q) sense_q <= sense_s3_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) mode_prev_q <= 2'b00;
    else     mode_prev_q <= pres_mode;
  end

  // test scheduling
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q      <= lrcr_pkg::DET_OFF;
      period_cnt_q <= '0;
      attempt_q    <= '0;
      win_cnt_q    <= '0;
      found_q      <= 1'b0;
    end else if (pres_mode != mode_prev_q || !auto_mode) begin
      // any mode change restarts detection from scratch
      state_q      <= auto_mode ? lrcr_pkg::DET_WAIT : lrcr_pkg::DET_OFF;
      period_cnt_q <= '0;
      attempt_q    <= '0;
      win_cnt_q    <= '0;
      found_q      <= 1'b0;
    end else begin
      unique case (state_q)
        lrcr_pkg::DET_OFF: begin
          state_q      <= lrcr_pkg::DET_WAIT;
          period_cnt_q <= '0;
        end
        lrcr_pkg::DET_WAIT: begin
          if (period_cnt_q == CNT_W'(PERIOD_CYC - 1)) begin
            state_q      <= lrcr_pkg::DET_TEST;
            period_cnt_q <= '0;
            win_cnt_q    <= '0;
          end else begin
            period_cnt_q <= period_cnt_q + 1'b1;
          end
        end
        lrcr_pkg::DET_TEST: begin
          win_cnt_q <= win_cnt_q + 1'b1;
          if (sense_q) begin
            found_q <= 1'b1;
            state_q <= lrcr_pkg::DET_DONE;
          end else if (win_cnt_q == WIN_W'(WINDOW_CYC - 1)) begin
            if (pres_mode == lrcr_pkg::PRES_DET_LIMITED) attempt_q <= attempt_q + 1'b1;
            if (pres_mode == lrcr_pkg::PRES_DET_LIMITED && attempt_q == ATT_W'(ATTEMPTS - 1))
              state_q <= lrcr_pkg::DET_DONE;
            else
              state_q <= lrcr_pkg::DET_WAIT;
          end
        end
        lrcr_pkg::DET_DONE: state_q <= lrcr_pkg::DET_DONE;
      endcase
    end
  end

  // termination: high-z, fixed 50 ohm, or 50 ohm once found
  always_ff @(posedge sys_clk) begin
    if (rst) term_50_q <= 1'b0;
    else     term_50_q <= (pres_mode == lrcr_pkg::PRES_FIXED_50) || (auto_mode && found_q);
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seq_wait_end;
    state_q == lrcr_pkg::DET_WAIT && period_cnt_q == CNT_W'(PERIOD_CYC - 1) && pres_mode == mode_prev_q && auto_mode;
  endsequence
  sequence seq_test_open;
    rx_test_pulse && !found_q;
  endsequence

  AST_TEST_AT_PERIOD:
  assert property (seq_wait_end |=> seq_test_open) else $error("test did not start at period end");
  AST_ATTEMPT_LIMIT:
  assert property (pres_mode == lrcr_pkg::PRES_DET_LIMITED |-> attempt_q <= ATT_W'(ATTEMPTS)
    && !(attempt_q == ATT_W'(ATTEMPTS) && rx_test_pulse))
    else $error("limited mode exceeded attempt count");
  AST_STOP_AFTER_LIMIT:
  assert property (state_q == lrcr_pkg::DET_DONE && !found_q && $stable(pres_mode) |=> !rx_test_pulse)
    else $error("testing continued after stop");
  AST_TERM_HIGHZ:
  assert property (pres_mode == lrcr_pkg::PRES_HIGHZ && $stable(pres_mode) |=> !term_50_q && !rx_test_pulse)
    else $error("termination not high-z in mode 00");
  AST_TERM_FIXED:
  assert property (pres_mode == lrcr_pkg::PRES_FIXED_50 && $stable(pres_mode) |=> term_50_q && !rx_test_pulse)
    else $error("termination not fixed 50 ohm in mode 11");
  AST_TERM_FOLLOWS_FOUND:
  assert property (auto_mode && $stable(pres_mode) |=> term_50_q == $past(found_q))
    else $error("auto termination does not follow detection");
endmodule : lrcr_rx_detect

// ---- verification/lrcr_far_end.sv ----
// Purpose: far-end receiver model answering the presence detect tests
// Assumes: rx_present is a level set by the bench
// Notes:   sense appears only once a test has seen the receiver
`timescale 1ns/1ns
module lrcr_far_end (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic rx_test_pulse,
  input  wire logic rx_present,
  output logic      far_rx_sense
);
  logic seen_q;

  // latched so a late synchronised sample still catches a present receiver
  always_ff @(posedge sys_clk) begin
    if (rst || !rx_present) begin
      seen_q <= 1'b0;
    end else if (rx_test_pulse) begin
      seen_q <= 1'b1;
    end
  end

  assign far_rx_sense = rx_present & (rx_test_pulse | seen_q);
endmodule : lrcr_far_end

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the lane 1 pair configuration registers
// Assumes: shortened detect period, three attempts in limited mode
// Notes:   expectations come from a register model held in the bench
`timescale 1ns/1ns
module tb_top;
  localparam int PER = 20;
  localparam int ATT = 3;
  logic       sys_clk, rst, reg_wr, reg_rd, reg_ack, idle_sensed, far_rx_sense, rx_present;
  logic       output_mute, input_term_50ohm, rx_test_pulse, short_protect_en, rate_class_gen12;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, input_boost_level, v;
  logic [1:0] rate_sensed, rate_exp;
  logic [2:0] output_swing_level, output_deemphasis_level;
  logic [7:0] mdl [0:3];
  logic [31:0] lfsr;
  logic       found_exp;
  logic       pulse_d = 1'b0;
  int         bad_count, checks, pulse_base;
  int         cyc = 0;
  int         pulse_cnt = 0;
  logic [7:0] it_reg [0:5] = '{8'h20, 8'h20, 8'h30, 8'h10, 8'h00, 8'h10};
  logic       it_idl [0:5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic       it_mut [0:5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  lrcr_regs #(.DETECT_PERIOD_CYC(PER), .DETECT_ATTEMPTS(ATT), .TEST_WINDOW_CYC(4)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .idle_sensed(idle_sensed),
    .rate_sensed(rate_sensed), .far_rx_sense(far_rx_sense), .output_mute(output_mute),
    .input_term_50ohm(input_term_50ohm), .rx_test_pulse(rx_test_pulse),
    .input_boost_level(input_boost_level), .short_protect_en(short_protect_en),
    .rate_class_gen12(rate_class_gen12), .output_swing_level(output_swing_level),
    .output_deemphasis_level(output_deemphasis_level));

  lrcr_far_end i_far (.sys_clk(sys_clk), .rst(rst), .rx_test_pulse(rx_test_pulse),
    .rx_present(rx_present), .far_rx_sense(far_rx_sense));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  function automatic logic [7:0] exp_of(input logic [7:0] a);
    if (a == lrcr_pkg::DEEMPH_OFFS) return {found_exp, rate_exp, mdl[3][4:0]};
    if (a >= lrcr_pkg::IDLE_PRES_OFFS && a < lrcr_pkg::DEEMPH_OFFS) return mdl[a - 8'h15];
    return lrcr_pkg::UNMAPPED_DATA;
  endfunction : exp_of

  task automatic close_out();
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t level %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    if (a >= lrcr_pkg::IDLE_PRES_OFFS && a <= lrcr_pkg::DEEMPH_OFFS) mdl[a - 8'h15] = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    chk_bit(reg_ack, 1'b1);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    chk_bit(reg_ack, 1'b1);
    chk_byte(reg_rdata, exp_of(a));
  endtask : reg_read

  always @(posedge sys_clk) begin
    pulse_d <= rx_test_pulse;
    if (rx_test_pulse === 1'b1 && pulse_d === 1'b0) pulse_cnt <= pulse_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, idle_sensed, rx_present} = '0;
    {reg_addr, reg_wdata, rate_sensed, rate_exp, found_exp} = '0;
    {bad_count, checks, pulse_base} = '0;
    mdl = '{lrcr_pkg::IDLE_PRES_RST, lrcr_pkg::EQ_RST, lrcr_pkg::SWING_RST, {3'h0, lrcr_pkg::DEEMPH_RST}};
    lfsr = 32'he043;
    wait_cyc(5);
    rst = 1'b0;
    for (int a = 8'h14; a <= 8'h19; a++) reg_read(8'(a));
    chk_bit(output_mute, 1'b0);
    chk_bit(input_term_50ohm, 1'b0);
    chk_byte({5'h00, output_swing_level}, 8'h05);
    chk_byte({5'h00, output_deemphasis_level}, 8'h02);
    reg_write(8'h19, 8'hff);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      v = lfsr[7:0];
      reg_write(lrcr_pkg::IDLE_PRES_OFFS, {2'b00, v[5:2], 2'b00});
      reg_write(lrcr_pkg::EQ_OFFS, lfsr[15:8]);
      reg_write(lrcr_pkg::SWING_OFFS, {lfsr[23:22], 3'b101, lfsr[18:16]});
      reg_write(lrcr_pkg::DEEMPH_OFFS, {lfsr[31:29], 2'b00, lfsr[26:24]});
      mdl[3][7:5] = 3'b000;
      chk_byte(input_boost_level, lfsr[15:8]);
      chk_bit(short_protect_en, lfsr[23]);
      chk_bit(rate_class_gen12, lfsr[22]);
      chk_byte({5'h00, output_swing_level}, {5'h00, lfsr[18:16]});
      chk_byte({5'h00, output_deemphasis_level}, {5'h00, lfsr[26:24]});
      chk_bit(output_mute, v[5] ? 1'b0 : v[4]);
      for (int a = 8'h14; a <= 8'h19; a++) reg_read(8'(a));
    end
    for (int i = 0; i < 6; i++) begin
      reg_write(lrcr_pkg::IDLE_PRES_OFFS, it_reg[i]);
      idle_sensed = it_idl[i];
      wait_cyc(8);
      chk_bit(output_mute, it_mut[i]);
    end
    for (int r = 0; r < 4; r++) begin
      rate_sensed = 2'(r);
      rate_exp = 2'(r);
      wait_cyc(8);
      reg_read(lrcr_pkg::DEEMPH_OFFS);
    end
    reg_write(lrcr_pkg::IDLE_PRES_OFFS, 8'h00);
    wait_cyc(2);
    chk_bit(input_term_50ohm, 1'b0);
    reg_write(lrcr_pkg::IDLE_PRES_OFFS, 8'h0c);
    wait_cyc(2);
    chk_bit(input_term_50ohm, 1'b1);
    reg_write(lrcr_pkg::IDLE_PRES_OFFS, 8'h04);
    pulse_base = pulse_cnt;
    wait_cyc(10 * PER);
    chk_byte(8'(pulse_cnt - pulse_base), 8'(ATT));
    chk_bit(input_term_50ohm, 1'b0);
    reg_write(lrcr_pkg::IDLE_PRES_OFFS, 8'h08);
    pulse_base = pulse_cnt;
    wait_cyc(8 * PER);
    chk_bit((pulse_cnt - pulse_base) > ATT, 1'b1);
    chk_bit(input_term_50ohm, 1'b0);
    rx_present = 1'b1;
    wait_cyc(3 * PER);
    chk_bit(input_term_50ohm, 1'b1);
    found_exp = 1'b1;
    reg_read(lrcr_pkg::DEEMPH_OFFS);
    reg_write(lrcr_pkg::IDLE_PRES_OFFS, 8'h0c);
    found_exp = 1'b0;
    wait_cyc(2);
    reg_read(lrcr_pkg::DEEMPH_OFFS);
    close_out();
  end
endmodule : tb_top
